// [serial_peer.sv]
`timescale 1ns/10ps
`default_nettype none
module serial_peer #(parameter int BIT_CLKS = 16) (
    // Clock
    input wire logic mclk,
    // Serial line
    input wire logic tx,
    input wire logic tx_oe,
    output logic rx
);
    logic [7:0] got;
    int got_cnt;
    initial begin
        rx = 1'b1;
        got = 8'h00;
        got_cnt = 0;
    end
    // One frame with optional parity bit and chosen stop level
    task automatic send(input logic [7:0] d, input logic use_par, input logic par,
                        input logic stop_lvl);
        rx <= 1'b0;
        repeat (BIT_CLKS) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            rx <= d[i];
            repeat (BIT_CLKS) @(posedge mclk);
        end
        if (use_par) begin
            rx <= par;
            repeat (BIT_CLKS) @(posedge mclk);
        end
        rx <= stop_lvl;
        repeat (BIT_CLKS) @(posedge mclk);
        rx <= 1'b1;
        repeat (BIT_CLKS) @(posedge mclk);
    endtask
    // Flip the line for one clock inside a bit, like noise
    task automatic glitch(input int wait_clks);
        repeat (wait_clks) @(posedge mclk);
        rx <= ~rx;
        @(posedge mclk);
        rx <= ~rx;
    endtask
    // Sample mid-bit, first bit is the lowest
    always @(negedge tx) begin
        if (tx_oe) begin
            repeat (BIT_CLKS / 2) @(posedge mclk);
            for (int k = 0; k < 8; k++) begin
                repeat (BIT_CLKS) @(posedge mclk);
                got[k] <= tx;
            end
            got_cnt <= got_cnt + 1;
        end
    end
endmodule
`default_nettype wire

// [tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic rx, tx, tx_oe, sync_module_active, rx_irq;
    int mismatches = 0;
    int n_compared = 0;
    logic [7:0] c1 [4] = '{8'h80, 8'hA0, 8'hB0, 8'hA0};
    logic [7:0] dat [4] = '{8'h33, 8'h01, 8'h01, 8'h03};
    logic [3:0] par [4] = '{4'h0, 4'h1, 4'h1, 4'h1};
    logic [3:0] pv [4] = '{4'h0, 4'h0, 4'h1, 4'h0};
    logic [7:0] est [4] = '{8'h2F, 8'h8F, 8'h8F, 8'h0F};
    always #2.5 mclk = ~mclk;
    uart_status_and_mode_select dut (.mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .rx(rx), .tx(tx), .tx_oe(tx_oe),
        .sync_module_active(sync_module_active), .rx_irq(rx_irq));
    serial_peer #(.BIT_CLKS(16)) peer (.mclk(mclk), .tx(tx), .tx_oe(tx_oe), .rx(rx));
    task automatic summarize();
        $display("Counts: %0d compared, %0d mismatches", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e,
                        input string name);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(name, rdata & m, e);
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rreg(3'h0, 8'hFF, uart_status_pkg::MODE_CTRL_RST, "mode");
        wreg(3'h3, 8'hA0);
        rreg(3'h3, 8'hFF, 8'h00, "ctrl two off");
        rreg(3'h1, 8'hFF, 8'h00, "status off");
        wreg(3'h0, 8'h02);
        repeat (3) @(posedge mclk);
        chk("sync on", {7'h00, sync_module_active}, 8'h01);
        wreg(3'h0, 8'h12);
        repeat (3) @(posedge mclk);
        chk("sync off", {7'h00, sync_module_active}, 8'h00);
        rreg(3'h1, 8'hFF, uart_status_pkg::STATUS_RST, "status");
        wreg(3'h1, 8'hF0);
        rreg(3'h1, 8'hFF, 8'h0B, "status ro");
        wreg(3'h5, 8'h00);
        wreg(3'h2, 8'h80);
        wreg(3'h3, 8'hA0);
        rreg(3'h1, 8'hFF, 8'h0B, "tx enabled");
        wreg(3'h4, 8'h5A);
        rreg(3'h1, 8'h02, 8'h00, "tx busy");
        for (int i = 0; i < 400 && peer.got_cnt < 1; i++) @(posedge mclk);
        if (peer.got_cnt < 1) begin
            chk("tx timeout", 8'h00, 8'h01);
            summarize();
        end
        chk("tx byte", peer.got, 8'h5A);
        repeat (40) @(posedge mclk);
        rreg(3'h1, 8'hFF, 8'h0B, "tx done");
        chk("tx line", {7'h00, tx}, 8'h01);
        chk("tx oe", {7'h00, tx_oe}, 8'h01);
        $display("test mode and tx done");
        wreg(3'h3, 8'hE4);
        fork
            peer.send(8'hA5, 1'b0, 1'b0, 1'b1);
            begin
                repeat (60) @(posedge mclk);
                rreg(3'h1, 8'h08, 8'h00, "rx busy");
            end
        join
        chk("irq", {7'h00, rx_irq}, 8'h01);
        rreg(3'h1, 8'hFF, 8'h0F, "rx avail");
        rreg(3'h4, 8'hFF, 8'hA5, "rx data");
        rreg(3'h1, 8'hFF, 8'h0B, "rx empty");
        for (int i = 0; i < 4; i++) begin
            wreg(3'h2, c1[i]);
            peer.send(dat[i], par[i][0], pv[i][0], i != 0);
            rreg(3'h1, 8'hFF, est[i], "err flags");
            rreg(3'h4, 8'hFF, dat[i], "err data");
            rreg(3'h1, 8'hFF, 8'h0B, "err clear");
        end
        wreg(3'h2, 8'h80);
        fork
            peer.send(8'h55, 1'b0, 1'b0, 1'b1);
            peer.glitch(29);
        join
        rreg(3'h1, 8'hFF, 8'h4F, "noise");
        rreg(3'h4, 8'hFF, 8'h55, "noise data");
        rreg(3'h1, 8'hFF, 8'h0B, "noise clear");
        $display("test rx errors done");
        wreg(3'h2, 8'h80);
        peer.send(8'h11, 1'b0, 1'b0, 1'b1);
        peer.send(8'h22, 1'b0, 1'b0, 1'b1);
        fork
            peer.send(8'h33, 1'b0, 1'b0, 1'b1);
            peer.glitch(29);
        join
        rreg(3'h1, 8'hFF, 8'h1F, "overrun");
        rreg(3'h4, 8'hFF, 8'h11, "first word");
        rreg(3'h1, 8'hFF, 8'h0F, "one left");
        rreg(3'h4, 8'hFF, 8'h22, "second word");
        rreg(3'h1, 8'hFF, 8'h0B, "drained");
        peer.send(8'hA5, 1'b0, 1'b0, 1'b0);
        wreg(3'h2, 8'h00);
        rreg(3'h1, 8'hFF, 8'h0B, "disabled");
        rreg(3'h3, 8'hFF, 8'h24, "enables off");
        chk("irq off", {7'h00, rx_irq}, 8'h00);
        chk("tx oe off", {7'h00, tx_oe}, 8'h00);
        $display("test overrun and disable done");
        summarize();
    end
endmodule
`default_nettype wire

// [uart_status_and_mode_select.sv]
// Overview of operation
// - One data address; writes feed transmitter, reads return received data.
// - Mode bit 4 selects async serial; bits 7:5 select sync modes otherwise.
// - Async registers exist only while async select bit is 1.
// - Sync enable bit 1 only acts when async select is 0.
// - Status is read only; resets with idle and tx-empty set, others clear.
// - Parity error bit 7 set on bad parity, only with parity enabled.
// - Status read then data access clears parity, noise, framing, overrun.
// - Noise bit 6 set on noisy receive, never on an overrun word.
// - Framing error bit 5 set when current character has bad stop bit.
// - Overrun bit 4 set on buffer overflow; blocks further data transfers.
// - Receiver idle bit 3 low from start detect to stop completion.
// - Word to data register sets receive-available bit 2, irq if enabled.
// - Error flags set in the same cycle as receive-available.
// - Receive-available clears after status read, data read, buffer empty.
// - Transmitter idle set when tx empty and nothing sending; line high.
// - Status read then data write clears tx idle; not set while queued.
// - Tx empty set when shift register takes the data character.
// - Status read with tx empty then data write clears tx empty.
// - Setting transmitter enable also sets tx empty.
// - Characters shift LSB first at baud generator rate.
// - Clearing port enable resets flags: idles and tx empty 1, others 0.
`timescale 1ns/10ps
`default_nettype none
module uart_status_and_mode_select (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Register port
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Serial line
    input wire logic rx,
    output logic tx,
    output logic tx_oe,
    // Mode and interrupt outputs
    output logic sync_module_active,
    output logic rx_irq
);
    logic [7:0] mode_q;
    logic [7:0] st_q;
    logic [7:0] c1_q;
    logic [7:0] c2_q;
    logic [7:0] baud_q;
    logic [7:0] seen_q;
    logic async_on;
    logic port_on;
    logic st_rd;
    logic data_rd;
    logic data_wr;
    logic rx_new;
    logic [8:0] rx_word;
    logic rx_perr;
    logic rx_ferr;
    logic rx_noise;
    logic tx_load;
    logic tx_busy;
    logic tick;

    assign async_on = mode_q[uart_status_pkg::MC_ASYNC];
    assign port_on = async_on && c1_q[uart_status_pkg::C1_PORT_EN];
    assign st_rd = rd && async_on && addr == uart_status_pkg::ADDR_STATUS;
    assign data_rd = rd && async_on && addr == uart_status_pkg::ADDR_DATA;
    assign data_wr = wr && async_on && addr == uart_status_pkg::ADDR_DATA;

    // Mode control register
    always_ff @(posedge mclk) begin
        if (srst) begin
            mode_q <= uart_status_pkg::MODE_CTRL_RST;
        end else if (wr && addr == uart_status_pkg::ADDR_MODE_CTRL) begin
            mode_q <= wdata;
        end
    end

    // Sync module enable effective only outside async mode
    always_ff @(posedge mclk) begin
        if (srst) begin
            sync_module_active <= 1'b0;
        end else begin
            sync_module_active <= !async_on && mode_q[uart_status_pkg::MC_SYNC_EN];
        end
    end

    // Control and baud registers; port disable clears tx/rx enables and break
    always_ff @(posedge mclk) begin
        if (srst) begin
            c1_q <= uart_status_pkg::ZERO8;
            c2_q <= uart_status_pkg::ZERO8;
            baud_q <= uart_status_pkg::ZERO8;
        end else begin
            if (wr && async_on && addr == uart_status_pkg::ADDR_CTRL_ONE) begin
                c1_q[7:2] <= wdata[7:2];
                c1_q[uart_status_pkg::C1_TX8] <= wdata[uart_status_pkg::C1_TX8];
            end
            if (rx_new) begin
                c1_q[uart_status_pkg::C1_RX8] <= rx_word[8];
            end
            if (wr && async_on && addr == uart_status_pkg::ADDR_CTRL_TWO) begin
                c2_q <= wdata;
            end
            if (wr && async_on && addr == uart_status_pkg::ADDR_BAUD) begin
                baud_q <= wdata;
            end
            if (!c1_q[uart_status_pkg::C1_PORT_EN]) begin
                c2_q[uart_status_pkg::C2_TX_EN] <= 1'b0;
                c2_q[uart_status_pkg::C2_RX_EN] <= 1'b0;
                c1_q[uart_status_pkg::C1_BREAK] <= 1'b0;
            end
        end
    end

    // Baud generator: one tick per oversample slot
    logic [7:0] bcnt_q;
    always_ff @(posedge mclk) begin
        if (srst || !port_on) begin
            bcnt_q <= uart_status_pkg::ZERO8;
            tick <= 1'b0;
        end else if (bcnt_q == baud_q) begin
            bcnt_q <= uart_status_pkg::ZERO8;
            tick <= 1'b1;
        end else begin
            bcnt_q <= bcnt_q + 8'h01;
            tick <= 1'b0;
        end
    end
    logic [5:0] ovs_top;
    assign ovs_top = c2_q[uart_status_pkg::C2_HIGH_SPEED] ?
        uart_status_pkg::OVS_HIGH : uart_status_pkg::OVS_LOW;

    // Transmit holding register and shifter
    logic [8:0] thr_q;
    logic thr_full_q;
    uart_status_pkg::tx_state_t txs_q;
    logic [8:0] tsh_q;
    logic [3:0] tbit_q;
    logic [5:0] tovs_q;
    logic tpar_q;
    logic tx_en;
    logic nine;
    assign tx_en = port_on && c2_q[uart_status_pkg::C2_TX_EN];
    assign nine = c1_q[uart_status_pkg::C1_NINE];
    assign tx_load = txs_q == uart_status_pkg::TX_IDLE && thr_full_q && tx_en;
    assign tx_busy = txs_q != uart_status_pkg::TX_IDLE || c1_q[uart_status_pkg::C1_BREAK];

    always_ff @(posedge mclk) begin
        if (srst || !tx_en) begin
            thr_q <= 9'h000;
            thr_full_q <= 1'b0;
        end else if (data_wr) begin
            thr_q <= {c1_q[uart_status_pkg::C1_TX8], wdata};
            thr_full_q <= 1'b1;
        end else if (tx_load) begin
            thr_full_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst || !tx_en) begin
            txs_q <= uart_status_pkg::TX_IDLE;
            tsh_q <= 9'h000;
            tbit_q <= 4'h0;
            tovs_q <= 6'h00;
            tpar_q <= 1'b0;
        end else if (tx_load) begin
            txs_q <= uart_status_pkg::TX_START;
            tsh_q <= thr_q;
            tbit_q <= 4'h0;
            tovs_q <= 6'h00;
            tpar_q <= c1_q[uart_status_pkg::C1_PAR_ODD];
        end else if (txs_q == uart_status_pkg::TX_IDLE && c1_q[uart_status_pkg::C1_BREAK]) begin
            txs_q <= uart_status_pkg::TX_BRK;
            tbit_q <= 4'h0;
            tovs_q <= 6'h00;
        end else if (tick && txs_q != uart_status_pkg::TX_IDLE) begin
            tovs_q <= tovs_q + 6'h01;
            if (tovs_q == ovs_top) begin
                tovs_q <= 6'h00;
                tbit_q <= tbit_q + uart_status_pkg::ONE4;
                unique case (txs_q)
                    uart_status_pkg::TX_START: begin
                        txs_q <= uart_status_pkg::TX_DATA;
                        tbit_q <= 4'h0;
                    end
                    uart_status_pkg::TX_DATA: begin
                        tpar_q <= tpar_q ^ tsh_q[0];
                        tsh_q <= {1'b0, tsh_q[8:1]};
                        if (tbit_q == (nine ? 4'h8 : 4'h7)) begin
                            txs_q <= c1_q[uart_status_pkg::C1_PAR_EN] ?
                                uart_status_pkg::TX_PAR : uart_status_pkg::TX_STOP;
                            tbit_q <= 4'h0;
                        end
                    end
                    uart_status_pkg::TX_PAR: begin
                        txs_q <= uart_status_pkg::TX_STOP;
                        tbit_q <= 4'h0;
                    end
                    uart_status_pkg::TX_STOP: begin
                        if (tbit_q == {3'h0, c1_q[uart_status_pkg::C1_TWO_STOP]}) begin
                            txs_q <= uart_status_pkg::TX_IDLE;
                        end
                    end
                    uart_status_pkg::TX_BRK: begin
                        if (tbit_q >= uart_status_pkg::BREAK_BITS - uart_status_pkg::ONE4
                            && !c1_q[uart_status_pkg::C1_BREAK]) begin
                            txs_q <= uart_status_pkg::TX_IDLE;
                        end
                        if (tbit_q == uart_status_pkg::BREAK_BITS) begin
                            tbit_q <= uart_status_pkg::BREAK_BITS;
                        end
                    end
                    default: begin
                        txs_q <= uart_status_pkg::TX_IDLE;
                    end
                endcase
            end
        end
    end

    // Line drive: idle high
    always_ff @(posedge mclk) begin
        if (srst) begin
            tx <= 1'b1;
            tx_oe <= 1'b0;
        end else begin
            tx_oe <= tx_en;
            unique case (txs_q)
                uart_status_pkg::TX_START: tx <= 1'b0;
                uart_status_pkg::TX_DATA: tx <= tsh_q[0];
                uart_status_pkg::TX_PAR: tx <= tpar_q;
                uart_status_pkg::TX_BRK: tx <= 1'b0;
                default: tx <= 1'b1;
            endcase
        end
    end

    // Receiver: 2-entry buffer including data register
    uart_status_pkg::rx_state_t rxs_q;
    logic [8:0] rsh_q;
    logic [3:0] rbit_q;
    logic [5:0] rovs_q;
    logic rpar_q;
    logic rnoise_q;
    logic rperr_q;
    logic rx_en;
    logic [8:0] rbuf_q [2];
    logic [1:0] rcnt_q;
    logic [2:0] rsamp_q;
    logic rmaj;
    assign rx_en = port_on && c2_q[uart_status_pkg::C2_RX_EN];
    assign rmaj = (rsamp_q[0] & rsamp_q[1]) | (rsamp_q[1] & rsamp_q[2]) | (rsamp_q[0] & rsamp_q[2]);

    always_ff @(posedge mclk) begin
        if (srst || !rx_en) begin
            rsamp_q <= 3'h7;
        end else if (tick) begin
            rsamp_q <= {rsamp_q[1:0], rx};
        end
    end

    always_ff @(posedge mclk) begin
        rx_new <= 1'b0;
        if (srst || !rx_en) begin
            rxs_q <= uart_status_pkg::RX_IDLE;
            rsh_q <= 9'h000;
            rbit_q <= 4'h0;
            rovs_q <= 6'h00;
            rpar_q <= 1'b0;
            rnoise_q <= 1'b0;
            rperr_q <= 1'b0;
            rx_word <= 9'h000;
            rx_perr <= 1'b0;
            rx_ferr <= 1'b0;
            rx_noise <= 1'b0;
        end else if (rxs_q == uart_status_pkg::RX_IDLE) begin
            if (!rx) begin
                rxs_q <= uart_status_pkg::RX_START;
                rovs_q <= 6'h00;
                rbit_q <= 4'h0;
                rnoise_q <= 1'b0;
                rpar_q <= c1_q[uart_status_pkg::C1_PAR_ODD];
                rperr_q <= 1'b0;
            end
        end else if (tick) begin
            rovs_q <= rovs_q + 6'h01;
            if (rovs_q == ovs_top) begin
                rovs_q <= 6'h00;
                if (!(&rsamp_q) && (|rsamp_q)) begin
                    rnoise_q <= 1'b1;
                end
                unique case (rxs_q)
                    uart_status_pkg::RX_START: begin
                        rxs_q <= rmaj ? uart_status_pkg::RX_IDLE : uart_status_pkg::RX_DATA;
                    end
                    uart_status_pkg::RX_DATA: begin
                        rsh_q <= nine ? {rmaj, rsh_q[8:1]} : {1'b0, rmaj, rsh_q[7:1]};
                        rpar_q <= rpar_q ^ rmaj;
                        rbit_q <= rbit_q + uart_status_pkg::ONE4;
                        if (rbit_q == (nine ? 4'h8 : 4'h7)) begin
                            rxs_q <= c1_q[uart_status_pkg::C1_PAR_EN] ?
                                uart_status_pkg::RX_PAR : uart_status_pkg::RX_STOP;
                        end
                    end
                    uart_status_pkg::RX_PAR: begin
                        rperr_q <= rpar_q ^ rmaj;
                        rxs_q <= uart_status_pkg::RX_STOP;
                    end
                    uart_status_pkg::RX_STOP: begin
                        rxs_q <= uart_status_pkg::RX_IDLE;
                        rx_new <= 1'b1;
                        rx_word <= rsh_q;
                        rx_ferr <= !rmaj;
                        rx_perr <= rperr_q && c1_q[uart_status_pkg::C1_PAR_EN];
                        rx_noise <= rnoise_q;
                    end
                    default: begin
                        rxs_q <= uart_status_pkg::RX_IDLE;
                    end
                endcase
            end
        end
    end

    // Receive buffer: push on word, pop on data read; blocked by overrun
    logic rx_push;
    logic rx_pop;
    assign rx_push = rx_new && !st_q[uart_status_pkg::ST_OVR]
        && rcnt_q != uart_status_pkg::RX_DEPTH;
    assign rx_pop = data_rd && rcnt_q != 2'h0;
    always_ff @(posedge mclk) begin
        if (srst || !rx_en) begin
            rcnt_q <= 2'h0;
            rbuf_q[0] <= 9'h000;
            rbuf_q[1] <= 9'h000;
        end else begin
            if (rx_pop) begin
                rbuf_q[0] <= rbuf_q[1];
            end
            if (rx_push) begin
                rbuf_q[(rx_pop || rcnt_q == 2'h0) ? 0 : 1] <= rx_word;
            end
            rcnt_q <= rcnt_q + {1'b0, rx_push} - {1'b0, rx_pop};
        end
    end

    // Per-flag status-read-seen-set tracking
    always_ff @(posedge mclk) begin
        if (srst || !port_on) begin
            seen_q <= uart_status_pkg::ZERO8;
        end else if (st_rd) begin
            seen_q <= st_q;
        end else if (data_rd || data_wr) begin
            seen_q <= uart_status_pkg::ZERO8;
        end
    end

    // Status flags: set beats clear, except tx idle where clear beats set
    logic rx_ovr;
    logic last_pop;
    assign rx_ovr = rx_new && !rx_push;
    assign last_pop = rx_pop && rcnt_q == 2'h1 && !rx_push;
    always_ff @(posedge mclk) begin
        if (srst || !port_on) begin
            st_q <= uart_status_pkg::STATUS_RST;
        end else begin
            if ((data_rd || data_wr)) begin
                st_q[7:4] <= st_q[7:4] & ~seen_q[7:4];
            end
            if (rx_push) begin
                st_q[uart_status_pkg::ST_RXAV] <= 1'b1;
                if (rx_perr) st_q[uart_status_pkg::ST_PERR] <= 1'b1;
                if (rx_ferr) st_q[uart_status_pkg::ST_FERR] <= 1'b1;
                if (rx_noise) st_q[uart_status_pkg::ST_NOISE] <= 1'b1;
            end else if (data_rd && seen_q[uart_status_pkg::ST_RXAV] && last_pop) begin
                st_q[uart_status_pkg::ST_RXAV] <= 1'b0;
            end
            if (rx_ovr) begin
                st_q[uart_status_pkg::ST_OVR] <= 1'b1;
            end
            st_q[uart_status_pkg::ST_RIDLE] <= rxs_q == uart_status_pkg::RX_IDLE;
            if (data_wr && seen_q[uart_status_pkg::ST_TXE]) begin
                st_q[uart_status_pkg::ST_TXE] <= 1'b0;
            end
            if (tx_load || (wr && addr == uart_status_pkg::ADDR_CTRL_TWO
                && wdata[uart_status_pkg::C2_TX_EN])) begin
                st_q[uart_status_pkg::ST_TXE] <= 1'b1;
            end
            if (data_wr && seen_q[uart_status_pkg::ST_TIDLE]) begin
                st_q[uart_status_pkg::ST_TIDLE] <= 1'b0;
            end else if (st_q[uart_status_pkg::ST_TXE] && !thr_full_q && !tx_busy) begin
                st_q[uart_status_pkg::ST_TIDLE] <= 1'b1;
            end
        end
    end

    // Receive interrupt request level
    always_ff @(posedge mclk) begin
        if (srst) begin
            rx_irq <= 1'b0;
        end else begin
            rx_irq <= st_q[uart_status_pkg::ST_RXAV] && c2_q[uart_status_pkg::C2_RX_IRQ_EN];
        end
    end

    // Read data one cycle after strobe; async registers hidden in sync mode
    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata <= uart_status_pkg::ZERO8;
        end else if (!rd) begin
            rdata <= uart_status_pkg::ZERO8;
        end else if (addr == uart_status_pkg::ADDR_MODE_CTRL) begin
            rdata <= mode_q;
        end else if (!async_on) begin
            rdata <= uart_status_pkg::ZERO8;
        end else begin
            unique case (addr)
                uart_status_pkg::ADDR_STATUS: rdata <= st_q;
                uart_status_pkg::ADDR_CTRL_ONE: rdata <= {c1_q[7:1], 1'b0};
                uart_status_pkg::ADDR_CTRL_TWO: rdata <= c2_q;
                uart_status_pkg::ADDR_DATA: rdata <= rbuf_q[0][7:0];
                uart_status_pkg::ADDR_BAUD: rdata <= baud_q;
                default: rdata <= uart_status_pkg::ZERO8;
            endcase
        end
    end

    // Checks
    reset_flags_a: assert property (@(posedge mclk) disable iff (srst)
        !port_on |=> (st_q == uart_status_pkg::STATUS_RST)) else $error("flags not reset");
    rxav_set_a: assert property (@(posedge mclk) disable iff (srst)
        rx_push && port_on |=> st_q[uart_status_pkg::ST_RXAV]) else $error("rx avail not set");
    ovr_block_a: assert property (@(posedge mclk) disable iff (srst)
        st_q[uart_status_pkg::ST_OVR] && rx_en && !rx_pop |=> rcnt_q == $past(rcnt_q))
        else $error("push during overrun");
    err_clear_a: assert property (@(posedge mclk) disable iff (srst)
        port_on && seen_q[uart_status_pkg::ST_FERR] && data_rd && !rx_push
        |=> !st_q[uart_status_pkg::ST_FERR]) else $error("framing not cleared");
    txe_load_a: assert property (@(posedge mclk) disable iff (srst)
        tx_load |=> st_q[uart_status_pkg::ST_TXE]) else $error("tx empty not set");
    ridle_a: assert property (@(posedge mclk) disable iff (srst)
        port_on && rxs_q == uart_status_pkg::RX_DATA |=> !st_q[uart_status_pkg::ST_RIDLE])
        else $error("rx idle during frame");
    tx_high_a: assert property (@(posedge mclk) disable iff (srst)
        txs_q == uart_status_pkg::TX_IDLE |=> tx) else $error("tx not idle high");
    hidden_a: assert property (@(posedge mclk) disable iff (srst)
        rd && !async_on && addr != uart_status_pkg::ADDR_MODE_CTRL |=> rdata == 8'h00)
        else $error("async reg visible");
    rx_word_c: cover property (@(posedge mclk) rx_push);
    tx_word_c: cover property (@(posedge mclk) tx_load);
    overrun_c: cover property (@(posedge mclk) rx_ovr);
endmodule
`default_nettype wire

// [uart_status_pkg.sv]
package uart_status_pkg;
    // Register addresses (byte offsets on the plain register port)
    localparam logic [2:0] ADDR_MODE_CTRL = 3'h0;
    localparam logic [2:0] ADDR_STATUS = 3'h1;
    localparam logic [2:0] ADDR_CTRL_ONE = 3'h2;
    localparam logic [2:0] ADDR_CTRL_TWO = 3'h3;
    localparam logic [2:0] ADDR_DATA = 3'h4;
    localparam logic [2:0] ADDR_BAUD = 3'h5;
    // Reset values
    localparam logic [7:0] MODE_CTRL_RST = 8'hE0;
    localparam logic [7:0] STATUS_RST = 8'h0B;
    localparam logic [7:0] ZERO8 = 8'h00;
    // Mode control fields
    localparam int MC_ASYNC = 4;
    localparam int MC_SYNC_EN = 1;
    localparam int MC_SYNC_HI = 7;
    localparam int MC_SYNC_LO = 5;
    // Status fields
    localparam int ST_PERR = 7;
    localparam int ST_NOISE = 6;
    localparam int ST_FERR = 5;
    localparam int ST_OVR = 4;
    localparam int ST_RIDLE = 3;
    localparam int ST_RXAV = 2;
    localparam int ST_TIDLE = 1;
    localparam int ST_TXE = 0;
    // Control one fields
    localparam int C1_PORT_EN = 7;
    localparam int C1_NINE = 6;
    localparam int C1_PAR_EN = 5;
    localparam int C1_PAR_ODD = 4;
    localparam int C1_TWO_STOP = 3;
    localparam int C1_BREAK = 2;
    localparam int C1_RX8 = 1;
    localparam int C1_TX8 = 0;
    // Control two fields
    localparam int C2_TX_EN = 7;
    localparam int C2_RX_EN = 6;
    localparam int C2_HIGH_SPEED = 5;
    localparam int C2_RX_IRQ_EN = 2;
    // Baud timing: ticks are 16 per bit (high speed) or 64 per bit (low)
    localparam logic [5:0] OVS_HIGH = 6'h0F;
    localparam logic [5:0] OVS_LOW = 6'h3F;
    localparam logic [3:0] BREAK_BITS = 4'hD;
    localparam logic [3:0] ONE4 = 4'h1;
    localparam logic [1:0] RX_DEPTH = 2'h2;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BRK} tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
endpackage
